// ---- flag_bank_pkg.sv ----
// shared constants for the special flag relay bank
`default_nettype none
package flag_bank_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CLOCK_HALF_MS = 500;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned CLOCK_HALF_CYCLES = CLOCK_HALF_MS * NS_PER_MS / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFF_CONTROL = 6'h00;
  localparam logic [5:0] OFF_STATUS = 6'h04;
  localparam logic [5:0] OFF_CAPTURE = 6'h08;
  localparam logic [5:0] OFF_EDGE = 6'h0c;
  localparam logic [5:0] OFF_RX_CANCEL = 6'h10;
  localparam logic [5:0] OFF_NET_STATUS = 6'h14;
  localparam logic [5:0] OFF_DISCONNECT = 6'h18;
  localparam logic [5:0] OFF_NET_EVENT = 6'h1c;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTL_RUN = 0;
  localparam int CTL_CLK_RESET = 1;
  localparam int CTL_OUTS_OFF = 2;
  localparam int CTL_LINK_PROHIBIT = 3;
  localparam int ST_CARRY = 0;
  localparam int ST_EXEC_ERR = 1;
  localparam int ST_COMM_ERR = 2;
  localparam int ST_RUNNING = 3;
  localparam int ST_ONE_SEC = 4;
  localparam int CAP_COUNTER_LSB = 4;
  localparam int NE_ADDR_CHANGE = 0;
  localparam int NE_TIME_WRITE = 1;
  // ---------------------------------------------------------------
  // group sizes and codes
  // ---------------------------------------------------------------
  localparam int CATCH_N = 4;
  localparam int EDGE_N = 4;
  localparam int COUNTER_N = 4;
  localparam int RX_CANCEL_N = 12;
  localparam int NET_STATUS_N = 14;
  localparam int DISCONNECT_N = 3;
  localparam logic [2:0] COMM_ERROR_PORT = 3'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
endpackage
`default_nettype wire

// ---- half_period_ticker.sv ----
// divider that pulses once per half period of the slow clock flag
`default_nettype none
module half_period_ticker #(
  parameter int unsigned CYCLES = 25000000
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic hold,
  // enable pulse
  output logic tick
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  logic [CNT_W-1:0] count;

  if (CYCLES < 2) begin : g_bad_cycles
    $error("half_period_ticker: CYCLES must be at least 2");
  end

  // hold restarts the phase so the clock comes back with a full half period
  always_ff @(posedge aclk) begin
    if (!aresetn || hold) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == CNT_W'(CYCLES - 1)) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // half_period_ticker
`default_nettype wire

// ---- special_flag_relay_bank.sv ----
// special control and status flag bank with an axi4-lite register port
//
// Summary of operation
// RULE1 - clearing the run control flag stops the running cpu.
// RULE2 - run control flag survives power-down; only backup loss resets it.
// RULE3 - outside party keeps run control set when stop input is used.
// RULE4 - after backup loss the cpu runs or stays stopped per selection.
// RULE5 - one-second clock reset flag holds the one-second clock off.
// RULE6 - all-outputs-off flag forces every output point off while set.
// RULE7 - self-held outputs stay released after all-outputs-off clears.
// RULE8 - carry/borrow flag set by add/subtract, also used by shift/rotate.
// RULE9 - execution error flag sets on any program execution error.
// RULE10 - port 2 link errors set a sticky comm error until cleared.
// RULE11 - link prohibit stops master link; survives power-off until cleared.
// RULE12 - catch input flags held on stop, cleared at power off.
// RULE13 - edge select set means rising; cleared on stop and power off.
// RULE14 - slim variant counter over/underflow held on stop, cleared at power off.
// RULE15 - receive cancel flags cleared on stop and at power off.
// RULE16 - connection status flags keep updating while stopped.
// RULE17 - client disconnect flags held on stop, cleared at power off.
// RULE18 - address change and time write flags keep working while stopped.
// RULE19 - one-second clock toggles with equal 500 ms halves.
// RULE20 - reserved flag addresses read zero and ignore writes.
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`default_nettype none
module special_flag_relay_bank
  import flag_bank_pkg::*;
#(
  parameter int NUM_OUTPUTS = 504,
  parameter int unsigned HALF_CYCLES = CLOCK_HALF_CYCLES,
  parameter bit SLIM_VARIANT = 1'b1
) (
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic backup_resetn,
  input wire logic run_on_backup_error,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // cpu execution
  input wire logic stop_request,
  output logic cpu_running,
  input wire logic carry_update,
  input wire logic carry_in,
  input wire logic exec_error_event,
  // serial link
  input wire logic comm_error_event,
  input wire logic [2:0] comm_error_port,
  input wire logic master_station,
  output logic link_stop,
  // output image
  input wire logic [NUM_OUTPUTS-1:0] out_image,
  output logic [NUM_OUTPUTS-1:0] out_drive,
  // capture and counters
  input wire logic catch_update,
  input wire logic [CATCH_N-1:0] catch_in,
  input wire logic [COUNTER_N-1:0] counter_wrap_event,
  output logic [EDGE_N-1:0] edge_rising,
  output logic [RX_CANCEL_N-1:0] rx_cancel,
  // network
  input wire logic [NET_STATUS_N-1:0] net_status_in,
  input wire logic [DISCONNECT_N-1:0] disconnect_event,
  input wire logic net_addr_change_event,
  input wire logic net_time_write_event,
  // slow clock
  output logic one_second_clock
);
  if (NUM_OUTPUTS < 1 || HALF_CYCLES < 2) begin : g_bad_param
    $error("special_flag_relay_bank: bad parameter");
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------------------------
  // flag state
  // ---------------------------------------------------------------
  logic run_control_flag, data_link_prohibit_flag;
  logic one_second_clock_reset_flag, all_outputs_off_flag;
  logic carry_borrow_flag, program_execution_error_flag, communication_error_flag;
  logic [CATCH_N-1:0] catch_input_status;
  logic [COUNTER_N-1:0] counter_overflow;
  logic [NET_STATUS_N-1:0] net_status;
  logic [DISCONNECT_N-1:0] client_disconnect;
  logic network_address_change_flag, network_time_write_flag;
  logic [NUM_OUTPUTS-1:0] released;
  logic half_tick;
  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  logic wr_fire, rd_fire;
  logic [31:0] wmask, wbits;
  logic [31:0] next_rdata;
  assign wr_fire = awvalid && wvalid && !awready && !bvalid;
  assign rd_fire = arvalid && !arready && !rvalid;
  assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  assign wbits = wdata & wmask;
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] off);
    return wr_fire && (a == off);
  endfunction

  // responses are always okay; registered so every bus output leaves a flop
  always_ff @(posedge aclk) begin
    bresp <= RESP_OKAY;
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
    end else begin
      awready <= wr_fire;
      wready <= wr_fire;
      if (wr_fire) bvalid <= 1'b1;
      else if (bready) bvalid <= 1'b0;
    end
  end
  always_comb begin
    next_rdata = '0;
    unique case (araddr)
      OFF_CONTROL: begin
        next_rdata[CTL_RUN] = run_control_flag;
        next_rdata[CTL_CLK_RESET] = one_second_clock_reset_flag;
        next_rdata[CTL_OUTS_OFF] = all_outputs_off_flag;
        next_rdata[CTL_LINK_PROHIBIT] = data_link_prohibit_flag;
      end
      OFF_STATUS: begin
        next_rdata[ST_CARRY] = carry_borrow_flag;
        next_rdata[ST_EXEC_ERR] = program_execution_error_flag;
        next_rdata[ST_COMM_ERR] = communication_error_flag;
        next_rdata[ST_RUNNING] = cpu_running;
        next_rdata[ST_ONE_SEC] = one_second_clock;
      end
      OFF_CAPTURE: begin
        next_rdata[CATCH_N-1:0] = catch_input_status;
        next_rdata[CAP_COUNTER_LSB +: COUNTER_N] = counter_overflow;
      end
      OFF_EDGE: next_rdata[EDGE_N-1:0] = edge_rising;
      OFF_RX_CANCEL: next_rdata[RX_CANCEL_N-1:0] = rx_cancel;
      OFF_NET_STATUS: next_rdata[NET_STATUS_N-1:0] = net_status;
      OFF_DISCONNECT: next_rdata[DISCONNECT_N-1:0] = client_disconnect;
      OFF_NET_EVENT: begin
        next_rdata[NE_ADDR_CHANGE] = network_address_change_flag;
        next_rdata[NE_TIME_WRITE] = network_time_write_flag;
      end
      default: next_rdata = '0; // RULE20
    endcase
  end
  always_ff @(posedge aclk) begin
    rresp <= RESP_OKAY;
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
    end else begin
      arready <= rd_fire;
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata <= next_rdata;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // retained flags: kept across power-down, lost only with the backup
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!backup_resetn) begin
      run_control_flag <= run_on_backup_error; // RULE4
      data_link_prohibit_flag <= 1'b0;
    end else if (hit(awaddr, OFF_CONTROL)) begin // RULE2
      if (wmask[CTL_RUN]) run_control_flag <= wbits[CTL_RUN];
      if (wmask[CTL_LINK_PROHIBIT]) data_link_prohibit_flag <= wbits[CTL_LINK_PROHIBIT]; // RULE11
    end
  end
  // stop input only governs while software keeps the run flag set
  always_ff @(posedge aclk) begin
    if (!aresetn) cpu_running <= 1'b0;
    else cpu_running <= run_control_flag && !stop_request; // RULE1 RULE3
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) link_stop <= 1'b0;
    else link_stop <= data_link_prohibit_flag && master_station; // RULE11
  end

  // ---------------------------------------------------------------
  // volatile control and error flags
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      one_second_clock_reset_flag <= 1'b0;
      all_outputs_off_flag <= 1'b0;
    end else if (hit(awaddr, OFF_CONTROL)) begin
      if (wmask[CTL_CLK_RESET]) one_second_clock_reset_flag <= wbits[CTL_CLK_RESET];
      if (wmask[CTL_OUTS_OFF]) all_outputs_off_flag <= wbits[CTL_OUTS_OFF];
    end
  end
  // the alu update wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) carry_borrow_flag <= 1'b0;
    else if (carry_update) carry_borrow_flag <= carry_in; // RULE8
    else if (hit(awaddr, OFF_STATUS) && wmask[ST_CARRY]) carry_borrow_flag <= wbits[ST_CARRY];
  end
  // error flags clear by writing one; a new error in that cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_execution_error_flag <= 1'b0;
      communication_error_flag <= 1'b0;
    end else begin
      if (exec_error_event) program_execution_error_flag <= 1'b1; // RULE9
      else if (hit(awaddr, OFF_STATUS) && wbits[ST_EXEC_ERR]) program_execution_error_flag <= 1'b0;
      if (comm_error_event && comm_error_port == COMM_ERROR_PORT) communication_error_flag <= 1'b1; // RULE10
      else if (hit(awaddr, OFF_STATUS) && wbits[ST_COMM_ERR]) communication_error_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // one-second clock
  // ---------------------------------------------------------------
  half_period_ticker #(.CYCLES(HALF_CYCLES)) u_ticker (
    .aclk(aclk),
    .aresetn(aresetn),
    .hold(one_second_clock_reset_flag),
    .tick(half_tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || one_second_clock_reset_flag) one_second_clock <= 1'b0; // RULE5
    else if (half_tick) one_second_clock <= !one_second_clock; // RULE19
  end

  // ---------------------------------------------------------------
  // output override; a point forced off stays off until its image drops
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_out
    always_ff @(posedge aclk) begin
      if (!aresetn) released[i] <= 1'b0;
      else if (all_outputs_off_flag && out_image[i]) released[i] <= 1'b1; // RULE7
      else if (!out_image[i]) released[i] <= 1'b0;
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) out_drive[i] <= 1'b0;
      else out_drive[i] <= out_image[i] && !all_outputs_off_flag && !released[i]; // RULE6 RULE7
    end
  end

  // ---------------------------------------------------------------
  // flags held while stopped
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) catch_input_status <= '0;
    else if (cpu_running && catch_update) catch_input_status <= catch_in; // RULE12
  end

  // only the slim variant carries these; elsewhere they read zero
  always_ff @(posedge aclk) begin
    if (!aresetn || !SLIM_VARIANT) counter_overflow <= '0;
    else if (cpu_running) counter_overflow <= counter_overflow | counter_wrap_event; // RULE14
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) client_disconnect <= '0;
    else if (cpu_running) client_disconnect <= client_disconnect | disconnect_event; // RULE17
  end

  // ---------------------------------------------------------------
  // flags cleared on stop; writes while stopped are dropped
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !cpu_running) begin
      edge_rising <= '0; // RULE13
      rx_cancel <= '0; // RULE15
    end else begin
      if (hit(awaddr, OFF_EDGE)) edge_rising <= wbits[EDGE_N-1:0] | (edge_rising & ~wmask[EDGE_N-1:0]);
      if (hit(awaddr, OFF_RX_CANCEL)) rx_cancel <= wbits[RX_CANCEL_N-1:0] | (rx_cancel & ~wmask[RX_CANCEL_N-1:0]);
    end
  end

  // ---------------------------------------------------------------
  // flags that keep operating while stopped
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) net_status <= '0;
    else net_status <= net_status_in; // RULE16
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      network_address_change_flag <= 1'b0;
      network_time_write_flag <= 1'b0;
    end else begin
      if (net_addr_change_event) network_address_change_flag <= 1'b1; // RULE18
      else if (hit(awaddr, OFF_NET_EVENT) && wbits[NE_ADDR_CHANGE]) network_address_change_flag <= 1'b0;
      if (net_time_write_event) network_time_write_flag <= 1'b1; // RULE18
      else if (hit(awaddr, OFF_NET_EVENT) && wbits[NE_TIME_WRITE]) network_time_write_flag <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_run_halts: assert property ((!run_control_flag ##1 !run_control_flag) |-> !cpu_running) // RULE1
    else $error("cpu still running with run control clear");
  chk_clock_held: assert property (one_second_clock_reset_flag |=> !one_second_clock) // RULE5
    else $error("one-second clock not held off");
  chk_outputs_off: assert property (all_outputs_off_flag |=> out_drive == '0) // RULE6
    else $error("output driven while all outputs off");
  chk_hold_released: assert property ((released != '0) |=> (out_drive & $past(released)) == '0) // RULE7
    else $error("released output came back on");
  chk_carry_follows: assert property (carry_update |=> carry_borrow_flag == $past(carry_in)) // RULE8
    else $error("carry flag did not follow the alu");
  chk_exec_error_set: assert property (exec_error_event |=> program_execution_error_flag) // RULE9
    else $error("execution error not flagged");
  chk_comm_error_sticky: assert property ( // RULE10
    (communication_error_flag && !(wr_fire && awaddr == OFF_STATUS)) |=> communication_error_flag)
    else $error("comm error dropped without a clear");
  chk_link_stop: assert property ((data_link_prohibit_flag && master_station) |=> link_stop) // RULE11
    else $error("master link not stopped");
  chk_stop_clears: assert property (!cpu_running |=> (edge_rising == '0 && rx_cancel == '0)) // RULE13 RULE15
    else $error("stop did not clear edge or cancel flags");
  chk_catch_held: assert property (!cpu_running |=> $stable(catch_input_status)) // RULE12
    else $error("catch status changed while stopped");
endmodule // special_flag_relay_bank
`default_nettype wire

// ---- special_flag_relay_bank_test.sv ----
// self-checking bench for the special flag relay bank
`default_nettype none
module special_flag_relay_bank_test
  import flag_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NO = 504;
  logic aclk = 1'b0, aresetn = 1'b0, backup_resetn = 1'b0, run_on_backup_error = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [5:0] awaddr = 6'h0, araddr = 6'h0;
  logic [31:0] wdata = 32'h0, r;
  logic [3:0] wstrb = 4'h0, catch_in = 4'h0, counter_wrap_event = 4'h0, edge_rising;
  logic awready, wready, bvalid, arready, rvalid, cpu_running, link_stop, one_second_clock, p;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic stop_request = 1'b0, carry_update = 1'b0, carry_in = 1'b0, exec_error_event = 1'b0;
  logic comm_error_event = 1'b0, master_station = 1'b0, catch_update = 1'b0;
  logic net_addr_change_event = 1'b0, net_time_write_event = 1'b0;
  logic [2:0] comm_error_port = 3'h0, disconnect_event = 3'h0;
  logic [11:0] rx_cancel;
  logic [13:0] net_status_in = 14'h0;
  logic [NO-1:0] out_image = '0, out_drive, img;
  logic [511:0] wide;
  integer seed = 32'h77fd9f56;
  int errors = 0, num_checks = 0, n;
  // behavioural model of the flag state
  int m_st = 0, m_cap = 0, m_dis = 0, m_edge = 0;

  special_flag_relay_bank #(.NUM_OUTPUTS(NO), .HALF_CYCLES(4)) dut (
    .aclk(aclk), .aresetn(aresetn), .backup_resetn(backup_resetn),
    .run_on_backup_error(run_on_backup_error),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .stop_request(stop_request), .cpu_running(cpu_running),
    .carry_update(carry_update), .carry_in(carry_in), .exec_error_event(exec_error_event),
    .comm_error_event(comm_error_event), .comm_error_port(comm_error_port),
    .master_station(master_station), .link_stop(link_stop), .out_image(out_image),
    .out_drive(out_drive), .catch_update(catch_update), .catch_in(catch_in),
    .counter_wrap_event(counter_wrap_event), .edge_rising(edge_rising), .rx_cancel(rx_cancel),
    .net_status_in(net_status_in), .disconnect_event(disconnect_event),
    .net_addr_change_event(net_addr_change_event), .net_time_write_event(net_time_write_event),
    .one_second_clock(one_second_clock)
  );

  always #10 aclk = ~aclk;

  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [NO-1:0] seen, input logic [NO-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
    end while (awready !== 1'b1 && k < 50);
    chk("wready", wready, 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1 && k < 50) begin
      @(posedge aclk);
      k++;
    end
    bready <= 1'b0;
    chk("bresp", bresp, RESP_OKAY);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] mask);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
    end while (rvalid !== 1'b1 && k < 50);
    chk("arready", arready, 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b0;
    chk($sformatf("reg %h", a), rdata & mask, exp);
    chk("rresp", rresp, RESP_OKAY);
  endtask

  task automatic test_done();
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // handshake waits give up after 50 cycles; this ends the run well after the sequence should be over
  initial begin
    cyc(5000);
    errors++;
    test_done();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    cyc(12);
    aresetn <= 1'b1;
    backup_resetn <= 1'b1;
    rd(OFF_CONTROL, 32'h1, '1);
    // hold the slow clock so status reads are fixed
    wr(OFF_CONTROL, 32'h3);
    cyc(3);
    chk("cpu_running", cpu_running, 1'b1);
    r = $random(seed);
    @(posedge aclk);
    catch_update <= 1'b1;
    catch_in <= r[3:0];
    counter_wrap_event <= r[7:4];
    disconnect_event <= r[10:8];
    carry_update <= 1'b1;
    carry_in <= 1'b1;
    exec_error_event <= 1'b1;
    comm_error_event <= 1'b1;
    comm_error_port <= 3'h3;
    @(posedge aclk);
    catch_update <= 1'b0;
    counter_wrap_event <= 4'h0;
    disconnect_event <= 3'h0;
    carry_update <= 1'b0;
    exec_error_event <= 1'b0;
    comm_error_event <= 1'b0;
    m_cap = r[7:0];
    m_dis = r[10:8];
    m_st = 3;
    rd(OFF_STATUS, m_st | 8, '1);
    @(posedge aclk);
    comm_error_event <= 1'b1;
    comm_error_port <= COMM_ERROR_PORT;
    @(posedge aclk);
    comm_error_event <= 1'b0;
    m_st = 7;
    cyc(4);
    rd(OFF_STATUS, m_st | 8, '1);
    rd(OFF_CAPTURE, m_cap, '1);
    rd(OFF_DISCONNECT, m_dis, '1);
    r = $random(seed);
    m_edge = r[3:0];
    wr(OFF_EDGE, r);
    wr(OFF_RX_CANCEL, r >> 4);
    cyc(2);
    chk("edge_rising", edge_rising, m_edge);
    chk("rx_cancel", rx_cancel, r[15:4]);
    rd(OFF_EDGE, m_edge, '1);
    wr(OFF_STATUS, 32'h6);
    m_st = 0;
    rd(OFF_STATUS, 32'h8, '1);
    for (int i = 0; i < 16; i++) wide[i*32 +: 32] = $random(seed);
    img = wide[NO-1:0];
    @(posedge aclk);
    out_image <= img;
    cyc(3);
    chk("out_drive", out_drive, img);
    wr(OFF_CONTROL, 32'h7);
    cyc(3);
    chk("out_drive", out_drive, '0);
    wr(OFF_CONTROL, 32'h3);
    cyc(3);
    chk("out_drive", out_drive, '0);
    out_image <= '0;
    cyc(3);
    out_image <= img;
    cyc(3);
    chk("out_drive", out_drive, img);
    // ---------------------------------------------------------------
    // stopped by the stop input, run flag kept set
    // ---------------------------------------------------------------
    stop_request <= 1'b1;
    cyc(3);
    chk("cpu_running", cpu_running, 1'b0);
    chk("edge_rising", edge_rising, '0);
    chk("rx_cancel", rx_cancel, '0);
    wr(OFF_EDGE, 32'hf);
    @(posedge aclk);
    catch_update <= 1'b1;
    catch_in <= ~r[3:0];
    counter_wrap_event <= 4'hf;
    disconnect_event <= 3'h7;
    net_status_in <= r[29:16];
    net_addr_change_event <= 1'b1;
    net_time_write_event <= 1'b1;
    @(posedge aclk);
    catch_update <= 1'b0;
    counter_wrap_event <= 4'h0;
    disconnect_event <= 3'h0;
    net_addr_change_event <= 1'b0;
    net_time_write_event <= 1'b0;
    cyc(2);
    rd(OFF_CAPTURE, m_cap, '1);
    rd(OFF_DISCONNECT, m_dis, '1);
    rd(OFF_NET_STATUS, r[29:16], '1);
    rd(OFF_NET_EVENT, 32'h3, '1);
    wr(OFF_NET_EVENT, 32'h1);
    rd(OFF_NET_EVENT, 32'h2, '1);
    rd(OFF_EDGE, 32'h0, '1);
    stop_request <= 1'b0;
    cyc(3);
    chk("cpu_running", cpu_running, 1'b1);
    wr(OFF_CONTROL, 32'h2);
    cyc(3);
    chk("cpu_running", cpu_running, 1'b0);
    repeat (10) begin
      @(posedge aclk);
      chk("one_second_clock", one_second_clock, 1'b0);
    end
    wr(OFF_CONTROL, 32'h0);
    p = one_second_clock;
    n = 0;
    while (one_second_clock === p && n < 20) begin
      @(posedge aclk);
      n++;
    end
    repeat (4) begin
      p = one_second_clock;
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (one_second_clock === p && n < 20);
      chk("half period", n, 4);
    end
    // ---------------------------------------------------------------
    // power cycle and backup loss
    // ---------------------------------------------------------------
    wr(OFF_CONTROL, 32'h9);
    master_station <= 1'b1;
    cyc(3);
    chk("link_stop", link_stop, 1'b1);
    aresetn <= 1'b0;
    cyc(3);
    aresetn <= 1'b1;
    rd(OFF_CONTROL, 32'h9, '1);
    rd(OFF_CAPTURE, 32'h0, '1);
    rd(OFF_DISCONNECT, 32'h0, '1);
    rd(OFF_NET_EVENT, 32'h0, '1);
    rd(OFF_STATUS, 32'h8, 32'hf);
    chk("link_stop", link_stop, 1'b1);
    run_on_backup_error <= 1'b0;
    backup_resetn <= 1'b0;
    cyc(2);
    backup_resetn <= 1'b1;
    rd(OFF_CONTROL, 32'h0, '1);
    cyc(2);
    chk("cpu_running", cpu_running, 1'b0);
    chk("link_stop", link_stop, 1'b0);
    wr(6'h24, 32'hffffffff);
    rd(6'h24, 32'h0, '1);
    rd(6'h3c, 32'h0, '1);
    test_done();
  end
endmodule // special_flag_relay_bank_test
`default_nettype wire
